// file: rtl/aux_pin_function_select.sv
// auxiliary pin function multiplexer with avalon registers
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module aux_pin_function_select #(
    parameter int unsigned LED_HOLD_CYCLES = aux_pin_pkg::LED_HOLD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // configuration storage read port
    output logic config_storage_read,
    input wire logic config_storage_valid,
    input wire logic config_storage_blank,
    input wire logic [20:0] config_storage_data,
    // device state from the bridge core
    input wire logic uart_tx_busy,
    input wire logic usb_configured,
    input wire logic usb_suspended,
    input wire logic charger_detected,
    input wire logic bang_write_strobe_n,
    input wire logic bang_read_strobe_n,
    input wire logic frame_start,
    input wire logic upload_traffic,
    input wire logic download_traffic,
    // auxiliary pins
    input wire logic [3:0] aux_pin_in,
    output logic [3:0] aux_pin_out,
    output logic [3:0] aux_pin_oe,
    output logic [3:0] aux_pin_pull_up,
    output logic [3:0] aux_pin_pull_down,
    // pin-sourced levels back to the core
    output logic bus_power_sense,
    output logic suspend_inhibit
);

    // true when a function drives the pin itself; gpio decided per pin
    function automatic logic drives_pin(input logic [4:0] sel);
        drives_pin = (sel != aux_pin_pkg::FN_FLOAT) && (sel != aux_pin_pkg::FN_GPIO) &&
            (sel != aux_pin_pkg::FN_BUS_POWER_SENSE) && (sel != aux_pin_pkg::FN_SUSPEND_INHIBIT) &&
            (sel <= aux_pin_pkg::FN_SUSPEND_INHIBIT);
    endfunction

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] mask;
        mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old & ~mask) | (wd & mask);
    endfunction

    aux_pin_pkg::load_state_type load_state_r;
    logic [19:0] func_r;
    logic pulldown_r;
    logic [3:0] gpio_out_r;
    logic [3:0] gpio_dir_r;
    logic [31:0] readdata_r;
    logic waitrequest_r;
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic frame_toggle_r;
    logic [3:0] pin_out_r;
    logic [3:0] pin_oe_r;
    logic [3:0] pull_up_r;
    logic [3:0] pull_down_r;
    logic bus_power_r;
    logic inhibit_r;
    logic [2:0] led_on;
    logic [2:0] led_trig;
    logic [2:0] clk_level;
    logic [31:0] src_level;
    logic loaded;
    logic access;
    logic [3:0] sense_hit;
    logic [3:0] inhibit_hit;
    logic [31:0] func_word;
    logic [31:0] gpio_word;
    logic [31:0] func_merged;
    logic [31:0] gpio_merged;

    assign loaded = (load_state_r == aux_pin_pkg::LOAD_DONE);
    assign access = (read || write) && !waitrequest_r;
    assign func_word = {11'h000, pulldown_r, func_r};
    assign gpio_word = {24'h000000, gpio_dir_r, gpio_out_r};
    assign func_merged = merge(func_word, writedata, byteenable);
    assign gpio_merged = merge(gpio_word, writedata, byteenable);

    // fetch selections from storage once after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            load_state_r <= aux_pin_pkg::LOAD_FETCH;
        end else begin
            unique case (load_state_r)
                aux_pin_pkg::LOAD_FETCH: begin
                    if (config_storage_valid) begin
                        load_state_r <= aux_pin_pkg::LOAD_DONE; // [R19]
                    end
                end
                aux_pin_pkg::LOAD_DONE: begin
                    load_state_r <= aux_pin_pkg::LOAD_DONE;
                end
            endcase
        end
    end

    assign config_storage_read = (load_state_r == aux_pin_pkg::LOAD_FETCH);

    // selections: storage load, then software
    always_ff @(posedge clk) begin
        if (reset) begin
            func_r <= aux_pin_pkg::FUNC_DEFAULT;
            pulldown_r <= aux_pin_pkg::FUNC_PULLDOWN_DEFAULT;
        end else if (!loaded && config_storage_valid) begin
            if (config_storage_blank) begin
                func_r <= aux_pin_pkg::FUNC_DEFAULT; // [R17]
                pulldown_r <= aux_pin_pkg::FUNC_PULLDOWN_DEFAULT;
            end else begin
                func_r <= config_storage_data[19:0]; // [R1] [R19]
                pulldown_r <= config_storage_data[aux_pin_pkg::FUNC_PULLDOWN_BIT];
            end
        end else if (access && write && address == aux_pin_pkg::REG_FUNC_SEL) begin
            func_r <= func_merged[19:0]; // [R1]
            pulldown_r <= func_merged[aux_pin_pkg::FUNC_PULLDOWN_BIT];
        end
    end

    // host-controlled gpio levels and directions
    always_ff @(posedge clk) begin
        if (reset) begin
            gpio_out_r <= aux_pin_pkg::GPIO_CTRL_RESET[3:0];
            gpio_dir_r <= aux_pin_pkg::GPIO_CTRL_RESET[7:4];
        end else if (access && write && address == aux_pin_pkg::REG_GPIO_CTRL) begin
            gpio_out_r <= gpio_merged[aux_pin_pkg::GPIO_OUT_LSB +: 4]; // [R11]
            gpio_dir_r <= gpio_merged[aux_pin_pkg::GPIO_DIR_LSB +: 4]; // [R11]
        end
    end

    // one wait state per access
    always_ff @(posedge clk) begin
        if (reset) begin
            waitrequest_r <= 1'b1;
        end else begin
            waitrequest_r <= !((read || write) && waitrequest_r);
        end
    end

    // read mux, unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            readdata_r <= 32'h00000000;
        end else if (read && waitrequest_r) begin
            if (address == aux_pin_pkg::REG_FUNC_SEL) begin
                readdata_r <= func_word;
            end else if (address == aux_pin_pkg::REG_GPIO_CTRL) begin
                readdata_r <= gpio_word;
            end else if (address == aux_pin_pkg::REG_STATUS) begin
                readdata_r <= 32'h00000000;
                readdata_r[aux_pin_pkg::STAT_PIN_LSB +: 4] <= pin_sync_r; // [R11]
                readdata_r[aux_pin_pkg::STAT_LOADED_BIT] <= loaded;
                readdata_r[aux_pin_pkg::STAT_BUS_POWER_BIT] <= bus_power_r;
                readdata_r[aux_pin_pkg::STAT_INHIBIT_BIT] <= inhibit_r;
                readdata_r[aux_pin_pkg::STAT_SUSPEND_BIT] <= usb_suspended;
            end else begin
                readdata_r <= 32'h00000000;
            end
        end
    end

    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;

    // two-stage synchroniser on the pin levels
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_r <= 4'hf;
            pin_sync_r <= 4'hf;
        end else begin
            pin_meta_r <= aux_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // start-of-frame toggle
    always_ff @(posedge clk) begin
        if (reset) begin
            frame_toggle_r <= 1'b0;
        end else if (frame_start) begin
            frame_toggle_r <= !frame_toggle_r; // [R15]
        end
    end

    // led pulse stretchers: upload, download, activity
    assign led_trig = {upload_traffic || download_traffic, download_traffic, upload_traffic}; // [R8]
    for (genvar k = 0; k < 3; k++) begin : g_led
        logic [31:0] hold_r;
        always_ff @(posedge clk) begin
            if (reset) begin
                hold_r <= 32'h00000000;
            end else if (led_trig[k]) begin
                hold_r <= 32'(LED_HOLD_CYCLES); // [R20] retrigger restarts
            end else if (hold_r != 32'h00000000) begin
                hold_r <= hold_r - 32'h00000001;
            end
        end
        assign led_on[k] = led_trig[k] || (hold_r != 32'h00000000);
    end

    // phase accumulators: no exact split of 100 mhz,
    // so mean frequency is right, edges jitter
    for (genvar k = 0; k < 3; k++) begin : g_nco
        localparam logic [15:0] INC = (k == 0) ? aux_pin_pkg::NCO_INC_24M :
            (k == 1) ? aux_pin_pkg::NCO_INC_12M : aux_pin_pkg::NCO_INC_6M;
        logic [15:0] acc_r;
        always_ff @(posedge clk) begin
            if (reset || usb_suspended) begin
                acc_r <= 16'h0000; // [R10] clocks stop low in suspend
            end else begin
                acc_r <= acc_r + INC; // [R10]
            end
        end
        assign clk_level[k] = acc_r[aux_pin_pkg::NCO_W - 1];
    end

    // level of each driving function by code
    always_comb begin
        src_level = 32'h00000000;
        src_level[aux_pin_pkg::FN_DRIVE_ONE] = 1'b1; // [R2]
        src_level[aux_pin_pkg::FN_DRIVE_ZERO] = 1'b0; // [R2]
        src_level[aux_pin_pkg::FN_DRIVER_ENABLE] = uart_tx_busy; // [R3]
        src_level[aux_pin_pkg::FN_POWER_SWITCH] = !(usb_configured && !usb_suspended); // [R4]
        src_level[aux_pin_pkg::FN_UPLOAD_LED] = !led_on[0]; // [R6]
        src_level[aux_pin_pkg::FN_DOWNLOAD_LED] = !led_on[1]; // [R7]
        src_level[aux_pin_pkg::FN_ACTIVITY_LED] = !led_on[2]; // [R8]
        src_level[aux_pin_pkg::FN_SUSPEND_IND] = !usb_suspended; // [R9]
        src_level[aux_pin_pkg::FN_CLOCK_24M] = clk_level[0]; // [R10]
        src_level[aux_pin_pkg::FN_CLOCK_12M] = clk_level[1]; // [R10]
        src_level[aux_pin_pkg::FN_CLOCK_6M] = clk_level[2]; // [R10]
        src_level[aux_pin_pkg::FN_CHARGER] = charger_detected; // [R12]
        src_level[aux_pin_pkg::FN_CHARGER_INV] = !charger_detected; // [R12]
        src_level[aux_pin_pkg::FN_WRITE_STROBE] = bang_write_strobe_n; // [R13]
        src_level[aux_pin_pkg::FN_READ_STROBE] = bang_read_strobe_n; // [R13]
        src_level[aux_pin_pkg::FN_FRAME_TOGGLE] = frame_toggle_r; // [R15]
    end

    // per-pin output, enable and pull registers
    for (genvar i = 0; i < 4; i++) begin : g_pin
        logic [4:0] sel;
        logic drive;
        logic pulled;
        assign sel = func_r[i * 5 +: 5];
        assign drive = (sel == aux_pin_pkg::FN_GPIO) ? gpio_dir_r[i] : drives_pin(sel);
        assign sense_hit[i] = (sel == aux_pin_pkg::FN_BUS_POWER_SENSE) && pin_sync_r[i];
        assign inhibit_hit[i] = (sel == aux_pin_pkg::FN_SUSPEND_INHIBIT) && !pin_sync_r[i];
        // unused codes float with no pull
        assign pulled = !drive && (sel != aux_pin_pkg::FN_FLOAT) && (sel <= aux_pin_pkg::FN_SUSPEND_INHIBIT);
        always_ff @(posedge clk) begin
            if (reset || !loaded) begin
                pin_oe_r[i] <= 1'b0; // [R19] floating until loaded
                pin_out_r[i] <= 1'b0;
                pull_up_r[i] <= 1'b0;
                pull_down_r[i] <= 1'b0;
            end else begin
                pin_oe_r[i] <= drive; // [R1] [R2]
                pin_out_r[i] <= (sel == aux_pin_pkg::FN_GPIO) ? gpio_out_r[i] : src_level[sel]; // [R11]
                pull_up_r[i] <= pulled && !(pulldown_r && usb_suspended); // [R18]
                pull_down_r[i] <= pulled && pulldown_r && usb_suspended; // [R18]
            end
        end
    end

    // levels sensed on input-function pins
    always_ff @(posedge clk) begin
        if (reset) begin
            bus_power_r <= 1'b0;
            inhibit_r <= 1'b0;
        end else begin
            bus_power_r <= loaded && (sense_hit != 4'h0); // [R14]
            inhibit_r <= loaded && (inhibit_hit != 4'h0); // [R16]
        end
    end

    assign aux_pin_out = pin_out_r;
    assign aux_pin_oe = pin_oe_r;
    assign aux_pin_pull_up = pull_up_r;
    assign aux_pin_pull_down = pull_down_r;
    assign bus_power_sense = bus_power_r;
    assign suspend_inhibit = inhibit_r;

endmodule

// file: common/aux_pin_pkg.sv
// constants of the auxiliary pin function multiplexer
//
// Notes on behaviour
// R1: each of four pins picks any function independently from stored configuration.
// R2: static options float the pin, drive constant one, or drive constant zero.
// R3: transmit-enable option drives the line-driver enable while the uart sends.
// R4: power-enable option is low once configured, high during suspend.
// R5: outside party should enable suspend pull-down when switching power with it.
// R6: upload led pulses low while uart receive bytes go to the host.
// R7: download led pulses low while host bytes leave on uart transmit.
// R8: activity led pulses low on usb traffic in either direction.
// R9: suspend indicator is low during suspend, high otherwise.
// R10: clock options give 24, 12 or 6 mhz, stopped during suspend.
// R11: general-purpose option makes pins individually host-controlled inputs or outputs.
// R12: charger option is high on dedicated charger; inverted option gives complement.
// R13: strobe options output the active-low bit-bang write or read strobe.
// R14: bus-power sense option makes the pin an input reporting bus power.
// R15: frame toggle option inverts the pin on every start-of-frame.
// R16: suspend-inhibit option is an input; low keeps device out of suspend.
// R17: unconfigured defaults: transmit enable, download led, upload led, suspend indicator.
// R18: input pins pulled up; stored option pulls them gently low in suspend.
// R19: selections load from storage after reset; pins float until loaded.
// R20: led pulses last a minimum visible time and retrigger during traffic.
package aux_pin_pkg;

    // function select codes
    localparam logic [4:0] FN_FLOAT = 5'h00;
    localparam logic [4:0] FN_DRIVE_ONE = 5'h01;
    localparam logic [4:0] FN_DRIVE_ZERO = 5'h02;
    localparam logic [4:0] FN_DRIVER_ENABLE = 5'h03;
    localparam logic [4:0] FN_POWER_SWITCH = 5'h04;
    localparam logic [4:0] FN_UPLOAD_LED = 5'h05;
    localparam logic [4:0] FN_DOWNLOAD_LED = 5'h06;
    localparam logic [4:0] FN_ACTIVITY_LED = 5'h07;
    localparam logic [4:0] FN_SUSPEND_IND = 5'h08;
    localparam logic [4:0] FN_CLOCK_24M = 5'h09;
    localparam logic [4:0] FN_CLOCK_12M = 5'h0a;
    localparam logic [4:0] FN_CLOCK_6M = 5'h0b;
    localparam logic [4:0] FN_GPIO = 5'h0c;
    localparam logic [4:0] FN_CHARGER = 5'h0d;
    localparam logic [4:0] FN_CHARGER_INV = 5'h0e;
    localparam logic [4:0] FN_WRITE_STROBE = 5'h0f;
    localparam logic [4:0] FN_READ_STROBE = 5'h10;
    localparam logic [4:0] FN_BUS_POWER_SENSE = 5'h11;
    localparam logic [4:0] FN_FRAME_TOGGLE = 5'h12;
    localparam logic [4:0] FN_SUSPEND_INHIBIT = 5'h13;

    // defaults when storage is blank, pin 3 in the top field
    localparam logic [19:0] FUNC_DEFAULT = {FN_SUSPEND_IND, FN_UPLOAD_LED, FN_DOWNLOAD_LED, FN_DRIVER_ENABLE};
    localparam logic FUNC_PULLDOWN_DEFAULT = 1'b0;

    // register byte offsets
    localparam logic [3:0] REG_FUNC_SEL = 4'h0;
    localparam logic [3:0] REG_GPIO_CTRL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // field positions
    localparam int unsigned FUNC_PULLDOWN_BIT = 20;
    localparam int unsigned GPIO_OUT_LSB = 0;
    localparam int unsigned GPIO_DIR_LSB = 4;
    localparam int unsigned STAT_PIN_LSB = 0;
    localparam int unsigned STAT_LOADED_BIT = 4;
    localparam int unsigned STAT_BUS_POWER_BIT = 5;
    localparam int unsigned STAT_INHIBIT_BIT = 6;
    localparam int unsigned STAT_SUSPEND_BIT = 7;
    localparam logic [7:0] GPIO_CTRL_RESET = 8'h00;

    // timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned LED_HOLD_NS = 50000000;
    localparam int unsigned LED_HOLD_CYCLES = (LED_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NCO_W = 16;
    localparam logic [15:0] NCO_INC_24M = 16'((24 * 65536) / CLK_MHZ);
    localparam logic [15:0] NCO_INC_12M = 16'((12 * 65536) / CLK_MHZ);
    localparam logic [15:0] NCO_INC_6M = 16'((6 * 65536) / CLK_MHZ);

    typedef enum logic [1:0] {
        LOAD_FETCH = 2'b01,
        LOAD_DONE = 2'b10
    } load_state_type;

endpackage

// file: verification/aux_pin_checker.sv
// port checks of the auxiliary pin multiplexer
`timescale 1ns/10ps
module aux_pin_checker #(
    parameter int unsigned LED_HOLD_CYCLES = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic waitrequest,
    // configuration storage
    input wire logic config_storage_read,
    input wire logic config_storage_valid,
    input wire logic config_storage_blank,
    input wire logic [20:0] config_storage_data,
    // core state
    input wire logic uart_tx_busy,
    input wire logic usb_suspended,
    input wire logic download_traffic,
    // pins
    input wire logic [3:0] aux_pin_out,
    input wire logic [3:0] aux_pin_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic [4:0] sel0_r;
    logic loaded_r;
    // pin 0 selection shadow; load beats an early write
    always_ff @(posedge clk) begin
        if (reset) begin
            loaded_r <= 1'b0;
            sel0_r <= 5'h00;
        end else if (config_storage_read && config_storage_valid) begin
            loaded_r <= 1'b1;
            sel0_r <= config_storage_blank ? aux_pin_pkg::FUNC_DEFAULT[4:0] : config_storage_data[4:0];
        end else if (write && !waitrequest && address == aux_pin_pkg::REG_FUNC_SEL && byteenable[0]) begin
            sel0_r <= writedata[4:0];
        end
    end
    // selection settled, pin register caught up
    sequence held(logic [4:0] code);
        (loaded_r && sel0_r == code) [*2];
    endsequence
    wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer");
    wait_once_a: assert property (!waitrequest |=> waitrequest)
        else $error("answer too long");
    load_drop_a: assert property (config_storage_read && config_storage_valid |=> !config_storage_read)
        else $error("fetch not ended");
    load_once_a: assert property (!config_storage_read |=> !config_storage_read)
        else $error("fetch repeated");
    float_load_a: assert property (config_storage_read |-> aux_pin_oe == 4'h0)
        else $error("early drive");
    zero_drive_a: assert property (held(aux_pin_pkg::FN_DRIVE_ZERO) |-> aux_pin_oe[0] && !aux_pin_out[0])
        else $error("zero wrong");
    one_drive_a: assert property (held(aux_pin_pkg::FN_DRIVE_ONE) |-> aux_pin_oe[0] && aux_pin_out[0])
        else $error("one wrong");
    driver_en_a: assert property (held(aux_pin_pkg::FN_DRIVER_ENABLE) |-> aux_pin_out[0] == $past(uart_tx_busy))
        else $error("enable wrong");
    suspend_ind_a: assert property (held(aux_pin_pkg::FN_SUSPEND_IND) |-> aux_pin_out[0] == !$past(usb_suspended))
        else $error("indicator wrong");
    led_hold_a: assert property (held(aux_pin_pkg::FN_DOWNLOAD_LED) ##0 $fell(download_traffic)
        |=> !aux_pin_out[0] [*2]) else $error("led too short");
endmodule
bind aux_pin_function_select aux_pin_checker #(.LED_HOLD_CYCLES(LED_HOLD_CYCLES)) chk (.*);

// file: verification/config_storage_model.sv
// storage model: one fetch per reset after a chosen delay
`timescale 1ns/10ps
module config_storage_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fetch port
    input wire logic config_storage_read,
    output logic config_storage_valid,
    output logic config_storage_blank,
    output logic [20:0] config_storage_data,
    // content and latency chosen by the bench
    input wire logic [20:0] store_word,
    input wire logic store_blank,
    input wire logic [3:0] store_delay
);
    logic [3:0] wait_r;
    // count while pending, then one valid pulse
    always_ff @(posedge clk) begin
        if (reset || !config_storage_read) begin
            wait_r <= 4'h0;
            config_storage_valid <= 1'b0;
        end else begin
            wait_r <= wait_r + 4'h1;
            config_storage_valid <= (wait_r == store_delay);
        end
    end
    // inverse outside valid, never a stale copy
    assign config_storage_data = config_storage_valid ? store_word : ~store_word;
    assign config_storage_blank = config_storage_valid ? store_blank : ~store_blank;
endmodule

// file: verification/test_aux_pin_function_select.sv
// self-checking bench for the auxiliary pin function multiplexer
`timescale 1ns/10ps
module test_aux_pin_function_select;
    localparam int unsigned HOLD = 8;
    logic clk, reset, read, write, waitrequest, config_storage_read, config_storage_valid, config_storage_blank;
    logic [3:0] address, byteenable, aux_pin_in, aux_pin_out, aux_pin_oe, aux_pin_pull_up, aux_pin_pull_down;
    logic [3:0] ext_drv, store_delay;
    logic [31:0] writedata, readdata, rd;
    logic [20:0] config_storage_data, store_word;
    logic uart_tx_busy, usb_configured, usb_suspended, charger_detected, bang_write_strobe_n, bang_read_strobe_n;
    logic frame_start, upload_traffic, download_traffic, bus_power_sense, suspend_inhibit, store_blank;
    logic [4:0] codes [4];
    int num_errors, check_count, cycles, cnt, want;
    aux_pin_function_select #(.LED_HOLD_CYCLES(HOLD)) uut (.*);
    config_storage_model store (.*);
    // far side drives floating pins
    assign aux_pin_in = (aux_pin_oe & aux_pin_out) | (~aux_pin_oe & ext_drv);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        check(32'({waitrequest, config_storage_read, aux_pin_oe}), 32'h30);
        reset <= 1'b0;
        @(posedge clk);
    endtask
    // {checkable, oe, out} per code
    function automatic logic [2:0] exp_pin(input logic [4:0] c);
        case (c)
            5'h01: return 3'b111;
            5'h02: return 3'b110;
            5'h03: return {2'b11, uart_tx_busy};
            5'h04: return {2'b11, !(usb_configured && !usb_suspended)};
            5'h05: return {upload_traffic, 2'b10};
            5'h06: return {download_traffic, 2'b10};
            5'h07: return {upload_traffic | download_traffic, 2'b10};
            5'h08: return {2'b11, !usb_suspended};
            5'h09, 5'h0a, 5'h0b, 5'h12: return 3'b000;
            5'h0d: return {2'b11, charger_detected};
            5'h0e: return {2'b11, !charger_detected};
            5'h0f: return {2'b11, bang_write_strobe_n};
            5'h10: return {2'b11, bang_read_strobe_n};
            default: return 3'b100;
        endcase
    endfunction
    task automatic check_pins(input logic [19:0] sel);
        logic [2:0] e;
        for (int p = 0; p < 4; p++) begin
            e = exp_pin(sel[p * 5 +: 5]);
            if (e[2])
                check(32'({aux_pin_oe[p], aux_pin_out[p] & e[1]}), 32'({e[1], e[0] & e[1]}));
        end
    endtask
    initial begin
        rd = $urandom(32'hb94c);
        {reset, read, write, frame_start, uart_tx_busy, usb_configured, usb_suspended} = 7'h40;
        {charger_detected, upload_traffic, download_traffic, address, writedata, ext_drv} = '0;
        {bang_write_strobe_n, bang_read_strobe_n, byteenable, store_word, store_blank, store_delay} = {6'h3f, 21'h0, 5'h19};
        {num_errors, check_count, cycles} = '0;
        // blank storage answers slowly; an early bus write must lose to the load
        do_reset();
        bus(1'b1, aux_pin_pkg::REG_FUNC_SEL, 32'h0);
        repeat (12) @(posedge clk);
        bus(1'b0, aux_pin_pkg::REG_FUNC_SEL, 32'h0);
        check(rd, {11'h0, aux_pin_pkg::FUNC_PULLDOWN_DEFAULT, aux_pin_pkg::FUNC_DEFAULT});
        {uart_tx_busy, download_traffic, usb_suspended} <= 3'b111;
        repeat (3) @(posedge clk);
        check_pins(aux_pin_pkg::FUNC_DEFAULT);
        // all codes, then random mixes
        for (int i = 0; i < 40; i++) begin
            for (int p = 0; p < 4; p++)
                codes[p] = (i < 8) ? 5'(i * 4 + p) : 5'($urandom_range(0, 31));
            {uart_tx_busy, usb_configured, usb_suspended, charger_detected, bang_write_strobe_n, bang_read_strobe_n,
                upload_traffic, download_traffic, ext_drv} <= 12'($urandom);
            bus(1'b1, aux_pin_pkg::REG_FUNC_SEL, {12'h0, codes[3], codes[2], codes[1], codes[0]});
            repeat (2) @(posedge clk);
            check_pins({codes[3], codes[2], codes[1], codes[0]});
        end
        // clock edges over 200 cycles, none in suspend
        for (int k = 0; k < 6; k++) begin
            usb_suspended <= k[0];
            bus(1'b1, aux_pin_pkg::REG_FUNC_SEL, 32'(aux_pin_pkg::FN_CLOCK_24M + k / 2));
            {cnt, rd} = 64'h1;
            want = k[0] ? 0 : 48 >> (k / 2);
            repeat (200) begin
                @(posedge clk);
                if (aux_pin_out[0] && !rd[0])
                    cnt++;
                rd[0] = aux_pin_out[0];
            end
            check(32'(cnt <= want && cnt + 1 >= want), 32'h1);
        end
        // start-of-frame toggling with spaced pulses
        {usb_suspended, upload_traffic, download_traffic} <= 3'b000;
        bus(1'b1, aux_pin_pkg::REG_FUNC_SEL, 32'(aux_pin_pkg::FN_FRAME_TOGGLE));
        repeat (2) @(posedge clk);
        rd[0] = aux_pin_out[0];
        for (int k = 1; k <= 3; k++) begin
            frame_start <= 1'b1;
            @(posedge clk);
            frame_start <= 1'b0;
            repeat (3) @(posedge clk);
            check(32'(aux_pin_out[0]), 32'(rd[0] ^ k[0]));
        end
        // refused: status write, unmapped read
        bus(1'b1, aux_pin_pkg::REG_STATUS, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        check(rd, 32'h0);
        // input functions and pulls
        bus(1'b1, aux_pin_pkg::REG_FUNC_SEL, {11'h0, 1'b1, aux_pin_pkg::FN_POWER_SWITCH, aux_pin_pkg::FN_SUSPEND_INHIBIT,
            aux_pin_pkg::FN_BUS_POWER_SENSE, aux_pin_pkg::FN_GPIO});
        for (int k = 0; k < 4; k++) begin
            {usb_configured, usb_suspended, ext_drv} <= {1'b1, k[1], 1'b0, ~k[0], k[0], 1'b0};
            repeat (6) @(posedge clk);
            check(32'({bus_power_sense, suspend_inhibit}), 32'({k[0], k[0]}));
            check(32'({aux_pin_pull_up[2:0], aux_pin_pull_down[2:0], aux_pin_oe[3], aux_pin_out[3]}),
                32'({k[1] ? 6'o07 : 6'o70, 1'b1, k[1]}));
            bus(1'b0, aux_pin_pkg::REG_STATUS, 32'h0);
            check(32'(rd[7:4]), 32'({k[1], k[0], k[0], 1'b1}));
        end
        // gpio direction and level
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, aux_pin_pkg::REG_GPIO_CTRL, 32'h10 | 32'(k));
            repeat (2) @(posedge clk);
            check(32'({aux_pin_oe[1:0], aux_pin_out[0]}), 32'({2'b01, k[0]}));
        end
        // one-cycle burst, led held low
        bus(1'b1, aux_pin_pkg::REG_FUNC_SEL, 32'(aux_pin_pkg::FN_DOWNLOAD_LED));
        download_traffic <= 1'b1;
        @(posedge clk);
        download_traffic <= 1'b0;
        cnt = 0;
        repeat (30) begin
            @(posedge clk);
            cnt += 32'(!aux_pin_out[0]);
        end
        check(32'(cnt >= HOLD && cnt <= HOLD + 3 && aux_pin_out[0]), 32'h1);
        // mid-run reset, programmed storage
        {store_word, store_blank, store_delay} <= {1'b1, aux_pin_pkg::FN_CHARGER_INV, aux_pin_pkg::FN_DRIVE_ONE,
            aux_pin_pkg::FN_FLOAT, aux_pin_pkg::FN_DRIVE_ZERO, 1'b0, 4'h1};
        do_reset();
        repeat (6) @(posedge clk);
        bus(1'b0, aux_pin_pkg::REG_FUNC_SEL, 32'h0);
        check(rd, 32'(store_word));
        check_pins(store_word[19:0]);
        bus(1'b0, aux_pin_pkg::REG_GPIO_CTRL, 32'h0);
        check(rd, 32'(aux_pin_pkg::GPIO_CTRL_RESET));
        conclude();
    end
endmodule
